// file: bench/sac_link_assertions.sv
// Pin-level checks on the converter link
`timescale 1ns/1ns
module sac_link_assertions #(
   parameter int BUSY_CYC = sac_pkg::BUSY_LOW_CYC
)
(
   input wire logic clk, // clock
   input wire logic rst_n, // sync reset, low
   input wire logic sel_n, // select, low
   input wire logic rd_conv, // read high, convert low
   input wire logic busy_n, // busy, low
   input wire logic [sac_pkg::RES_W-1:0] result_bus_o, // result word
   input wire logic result_bus_oe // bus drive enable
);
   localparam int LEAD = sac_pkg::BUSY_AFTER_DATA_CYC;
   logic [11:0] low_cnt;
   // Busy length is counted here so the bound stays a plain compare
   always_ff @(posedge clk)
   begin
      low_cnt <= (!rst_n || busy_n) ? 12'h000 : low_cnt + 12'h001;
   end
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // ************************************
   // Busy timing and bus drive
   // ************************************
   chk_start_busy: assert property (busy_n && !sel_n && !rd_conv |=> !busy_n)
      else $error("busy_n did not fall after a start");
   chk_low_hold: assert property (!busy_n && low_cnt < BUSY_CYC - 1 |=> !busy_n)
      else $error("busy_n rose early");
   chk_busy_width: assert property ($rose(busy_n) |-> low_cnt == BUSY_CYC)
      else $error("busy_n low time wrong");
   chk_busy_max: assert property (low_cnt <= BUSY_CYC)
      else $error("busy_n low too long");
   chk_oe_decode: assert property (
      result_bus_oe == (!$past(sel_n) && $past(rd_conv) && busy_n))
      else $error("bus drive decode wrong");
   chk_sel_float: assert property (sel_n |=> !result_bus_oe)
      else $error("bus driven while deselected");
   chk_read_after: assert property (
      $rose(busy_n) && !$past(sel_n) && $past(rd_conv) |-> result_bus_oe)
      else $error("pending read not enabled");
   chk_result_hold: assert property (
      result_bus_oe && $past(result_bus_oe) |-> $stable(result_bus_o))
      else $error("result changed while read");
   chk_data_lead: assert property (
      $rose(busy_n) |-> result_bus_o == $past(result_bus_o, LEAD))
      else $error("result not settled before busy_n rose");
   chk_conv_float: assert property (!rd_conv |=> !result_bus_oe)
      else $error("bus driven in convert mode");
endmodule

// file: bench/test_sac_link.sv
// Self-checking bench for the converter control link
`timescale 1ns/1ns
module test_sac_link;
   localparam int BUSY = 20;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic conv_req = 1'b0;
   logic s_valid = 1'b0;
   logic s2_valid = 1'b0;
   logic [11:0] s_data = 12'h000;
   logic conv_ready;
   logic rd_valid;
   logic s_ready;
   logic s2_ready;
   logic [11:0] rd_data;
   logic [11:0] q[$];
   logic [11:0] d;
   logic [11:0] codes[4] = '{12'h7FF, 12'h000, 12'hFFF, 12'h800};
   int miscompares = 0;
   int check_count = 0;
   sac_link_if link();
   sac_link_if link2();
   always #2 clk = ~clk;
   sac_dev #(.BUSY_CYC(BUSY)) sac_dev_inst (.clk(clk), .rst_n(rst_n), .link(link),
      .sample_data(s_data), .sample_valid(s_valid), .sample_ready(s_ready));
   // Second end driven by the bench to reach every control combination
   sac_dev #(.BUSY_CYC(BUSY)) sac_dev_inst2 (.clk(clk), .rst_n(rst_n), .link(link2),
      .sample_data(s_data), .sample_valid(s2_valid), .sample_ready(s2_ready));
   sac_host sac_host_inst (.clk(clk), .rst_n(rst_n), .link(link), .conv_req(conv_req),
      .conv_ready(conv_ready), .rd_data(rd_data), .rd_valid(rd_valid));
   sac_link_assertions #(.BUSY_CYC(BUSY)) sac_link_assertions_inst (.clk(clk),
      .rst_n(rst_n), .sel_n(link.sel_n), .rd_conv(link.rd_conv), .busy_n(link.busy_n),
      .result_bus_o(link.result_bus_o), .result_bus_oe(link.result_bus_oe));
   // ************************************
   // Helpers
   // ************************************
   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic logic exp_oe(input logic sel, input logic rc, input logic busy);
      return !sel && rc && busy;
   endfunction
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic wait_hi(input int sig, input int lim);
      int n;
      n = 0;
      while ((sig == 0 ? conv_ready : rd_valid) !== 1'b1 && n < lim)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n >= lim)
      begin
         miscompares++;
         end_of_test();
      end
   endtask
   task automatic push(input logic second, input logic [11:0] v);
      s_data = v;
      if (second)
         s2_valid = 1'b1;
      else
         s_valid = 1'b1;
      check(second ? s2_ready : s_ready, 1'b1);
      @(posedge clk);
      #1;
   endtask
   task automatic drive2(input logic sel, input logic rc);
      link2.sel_n = sel;
      link2.rd_conv = rc;
      @(posedge clk);
      #1;
   endtask
   // Pulsing rd_conv low mid-conversion is a command that must be ignored
   task automatic conv2(input logic [11:0] exp, input logic cs_last, input logic keep_low);
      int n;
      n = 0;
      // other line low a full setup first
      repeat (sac_pkg::SETUP_CYC) drive2(cs_last, !cs_last);
      drive2(1'b0, 1'b0);
      check(link2.busy_n, 1'b0);
      check(link2.result_bus_oe, 1'b0);
      while (n < 100)
      begin
         @(posedge clk);
         #1;
         n++;
         if (link2.busy_n === 1'b1)
            break;
         check(link2.result_bus_oe, 1'b0);
         if (n == BUSY - sac_pkg::BUSY_AFTER_DATA_CYC)
            check(link2.result_bus_o, exp);
         link2.rd_conv = !(keep_low || n < 9 || n == 11 || n == 12);
      end
      check(12'(n), 12'(BUSY));
      if (n >= 100)
         end_of_test();
      check(link2.result_bus_oe, exp_oe(1'b0, !keep_low, 1'b1));
      if (!keep_low)
         check(link2.result_bus_o, exp);
      drive2(1'b1, 1'b1);
      check(link2.result_bus_oe, 1'b0);
      if (keep_low)
      begin
         drive2(1'b0, 1'b1);
         check(link2.result_bus_oe, 1'b1);
         check(link2.result_bus_o, exp);
         drive2(1'b1, 1'b1);
      end
   endtask
   // ************************************
   // Main sequence
   // ************************************
   initial
   begin
      link2.sel_n = 1'b1;
      link2.rd_conv = 1'b1;
      void'($urandom(73398));
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         d = (i < 4) ? codes[i] : 12'($urandom);
         push(1'b0, d);
         s_valid = 1'b0;
         wait_hi(0, 600);
         conv_req = 1'b1;
         @(posedge clk);
         #1;
         conv_req = 1'b0;
         check(conv_ready, 1'b0);
         wait_hi(1, 200);
         check(rd_data, d);
      end
      $display("Host read test done");
      for (int k = 1; k < 4; k++)
      begin
         drive2(k[1], k[0]);
         check(link2.result_bus_oe, exp_oe(k[1], k[0], 1'b1));
      end
      $display("Link decode test done");
      for (int i = 0; i < 16; i++)
      begin
         d = 12'($urandom);
         q.push_back(d);
         push(1'b1, d);
      end
      s_data = ~d;
      check(s2_ready, 1'b0);
      @(posedge clk);
      #1;
      s2_valid = 1'b0;
      for (int i = 0; i < 17; i++)
         conv2(q[i < 16 ? i : 15], i[0], i == 15);
      $display("Fifo drain test done");
      end_of_test();
   end
endmodule

// file: src/sac_dev.sv
// Converter end: control decode, busy timing, result register and bus drive
// Contract
// RULE_01: both lines low starts conversion, hold 40ns
// RULE_02: busy_n low until result stored, <=1440ns
// RULE_03: commands ignored while busy_n low
// RULE_04: host spaces convert commands 1660ns apart
// RULE_05: lines OR-combined, level acting, 10ns setup
// RULE_06: bus driven only read, selected, idle
// RULE_07: one 12-bit two's complement word, MSB high
// RULE_08: codes 7FF, 000, FFF, 800 map scale
// RULE_09: busy_n rises 20ns after result valid
// RULE_10: select fall in read mode enables bus
// RULE_11: read/convert fall while selected starts conversion
// RULE_12: select fall with convert low starts conversion
// RULE_13: select high means bus floating
// RULE_14: pending read enables bus after conversion
// RULE_15: both low at completion: store, float
// RULE_16: select tied low: read/convert alone controls
// RULE_17: busy_n within 125ns, data within 1460ns
// RULE_18: host keeps data bus quiet converting
// RULE_19: busy_n falls at start, rises after latch
// RULE_20: result held until next conversion completes
`timescale 1ns/1ns
module sac_dev #(
   parameter int BUSY_CYC = sac_pkg::BUSY_LOW_CYC,
   parameter int DEPTH = 16
)
(
   input wire logic clk, // clock
   input wire logic rst_n, // sync reset, low
   sac_link_if.dev link, // pins toward host
   input wire logic [sac_pkg::RES_W-1:0] sample_data, // digitised sample
   input wire logic sample_valid, // sample word offered
   output logic sample_ready // sample word taken
);
   initial
   begin
      if (BUSY_CYC > sac_pkg::BUSY_LOW_CYC || BUSY_CYC <= sac_pkg::BUSY_AFTER_DATA_CYC)
         $error("sac_dev: BUSY_CYC out of range");
   end
   typedef enum logic [1:0] {
      S_IDLE = 2'b01,
      S_CONV = 2'b10
   } sac_dev_state_t;
   typedef struct packed {
      sac_dev_state_t state;
      logic [sac_pkg::CNT_W-1:0] cnt;
      logic [sac_pkg::RES_W-1:0] result;
      logic busy_n;
      logic drive;
   } sac_dev_st_t;
   sac_dev_st_t st, next_st;
   logic fifo_valid, fifo_ready;
   logic [sac_pkg::RES_W-1:0] fifo_data;
   logic start;
   // Samples queue here; a full queue pushes back on the sampling source
   sac_fifo #(
      .WIDTH(sac_pkg::RES_W),
      .DEPTH(DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst_n(rst_n),
      .in_valid(sample_valid),
      .in_ready(sample_ready),
      .in_data(sample_data),
      .out_valid(fifo_valid),
      .out_ready(fifo_ready),
      .out_data(fifo_data)
   );
   // RULE_01 RULE_05 level OR start
   // RULE_11 RULE_12 RULE_16 either-line start
   assign start = !link.sel_n && !link.rd_conv;
   // Word is latched a full settle time before busy_n rises, so a host that
   // captures on that rising edge always sees stable data
   assign fifo_ready = (st.state == S_CONV) &&
      (st.cnt == sac_pkg::CNT_W'(BUSY_CYC - 1 - sac_pkg::BUSY_AFTER_DATA_CYC));
   // **************************************************
   // Next state
   // **************************************************
   always_comb
   begin
      next_st = st;
      case (st.state)
         S_IDLE:
         begin
            // RULE_03 RULE_19 start only when idle
            if (start)
            begin
               next_st.state = S_CONV;
               next_st.cnt = '0;
               // RULE_17 busy_n falls next edge
               next_st.busy_n = 1'b0;
            end
         end
         S_CONV:
         begin
            next_st.cnt = st.cnt + 1'b1;
            // RULE_07 RULE_08 RULE_09 RULE_20 latch word early
            if (fifo_ready)
               next_st.result = fifo_valid ? fifo_data : st.result;
            // RULE_02 RULE_17 bounded busy time
            if (st.cnt == sac_pkg::CNT_W'(BUSY_CYC - 1))
            begin
               next_st.state = S_IDLE;
               next_st.busy_n = 1'b1;
            end
         end
         default:
         begin
            next_st.state = S_IDLE;
            next_st.busy_n = 1'b1;
         end
      endcase
      // RULE_06 RULE_10 RULE_13 RULE_14 RULE_15 drive decode
      next_st.drive = !link.sel_n && link.rd_conv && next_st.busy_n;
   end
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st.state <= S_IDLE;
         st.cnt <= '0;
         st.result <= sac_pkg::RESULT_RST;
         st.busy_n <= 1'b1;
         st.drive <= 1'b0;
      end
      else
         st <= next_st;
   end
   assign link.busy_n = st.busy_n;
   assign link.result_bus_o = st.result;
   assign link.result_bus_oe = st.drive;
endmodule

// file: src/sac_fifo.sv
// Parameterised valid/ready FIFO for result words
`timescale 1ns/1ns
module sac_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 16
)
(
   input wire logic clk, // clock
   input wire logic rst_n, // sync reset, low
   input wire logic in_valid, // write request
   output logic in_ready, // not full
   input wire logic [WIDTH-1:0] in_data, // write word
   output logic out_valid, // not empty
   input wire logic out_ready, // drain accepts
   output logic [WIDTH-1:0] out_data // head word
);
   localparam int AW = $clog2(DEPTH);
   initial
   begin
      if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
         $error("sac_fifo: DEPTH must be a power of two >= 2");
   end
   typedef struct packed {
      logic [AW:0] wp;
      logic [AW:0] rp;
   } sac_fifo_st_t;
   sac_fifo_st_t st, next_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic do_wr, do_rd;
   assign in_ready = (st.wp - st.rp) != (AW+1)'(DEPTH);
   assign out_valid = st.wp != st.rp;
   assign do_wr = in_valid && in_ready;
   assign do_rd = out_valid && out_ready;
   assign out_data = mem[st.rp[AW-1:0]];
   always_comb
   begin
      next_st = st;
      if (do_wr)
         next_st.wp = st.wp + 1'b1;
      if (do_rd)
         next_st.rp = st.rp + 1'b1;
   end
   always_ff @(posedge clk)
   begin
      if (!rst_n)
         st <= '0;
      else
         st <= next_st;
      if (do_wr)
         mem[st.wp[AW-1:0]] <= in_data;
   end
endmodule

// file: src/sac_host.sv
// Host end: issues convert pulses and reads results off the link
`timescale 1ns/1ns
module sac_host #(
   parameter int GAP_CYC = sac_pkg::BETWEEN_CONV_CYC
)
(
   input wire logic clk, // clock
   input wire logic rst_n, // sync reset, low
   sac_link_if.host link, // pins toward converter
   input wire logic conv_req, // request one conversion
   output logic conv_ready, // request can be taken
   output logic [sac_pkg::RES_W-1:0] rd_data, // result read back
   output logic rd_valid // one-cycle result strobe
);
   initial
   begin
      if (GAP_CYC < sac_pkg::BETWEEN_CONV_CYC || GAP_CYC > 4095)
         $error("sac_host: GAP_CYC out of range");
   end
   typedef enum logic [3:0] {
      H_IDLE = 4'b0001,
      H_SETUP = 4'b0010,
      H_PULSE = 4'b0100,
      H_WAIT = 4'b1000
   } sac_host_state_t;
   typedef struct packed {
      sac_host_state_t state;
      logic [sac_pkg::CNT_W-1:0] cnt;
      logic [sac_pkg::CNT_W-1:0] gap;
      logic sel_n;
      logic rd_conv;
      logic busy_seen;
      logic [sac_pkg::RES_W-1:0] data;
      logic valid;
   } sac_host_st_t;
   sac_host_st_t st, next_st;
   assign conv_ready = (st.state == H_IDLE) && (st.gap == '0);
   // **************************************************
   // Next state
   // **************************************************
   always_comb
   begin
      next_st = st;
      next_st.valid = 1'b0;
      next_st.cnt = st.cnt + 1'b1;
      // RULE_04 spacing between commands
      if (st.gap != '0)
         next_st.gap = st.gap - 1'b1;
      case (st.state)
         H_IDLE:
         begin
            if (conv_req && conv_ready)
            begin
               // RULE_05 convert line low before select
               next_st.rd_conv = 1'b0;
               next_st.state = H_SETUP;
               next_st.cnt = '0;
               next_st.gap = sac_pkg::CNT_W'(GAP_CYC);
            end
         end
         H_SETUP:
         begin
            if (st.cnt == sac_pkg::CNT_W'(sac_pkg::SETUP_CYC - 1))
            begin
               next_st.sel_n = 1'b0;
               next_st.state = H_PULSE;
               next_st.cnt = '0;
               next_st.busy_seen = 1'b0;
            end
         end
         H_PULSE:
         begin
            if (!link.busy_n)
               next_st.busy_seen = 1'b1;
            // RULE_01 hold both low 40ns
            if (st.cnt >= sac_pkg::CNT_W'(sac_pkg::CONV_PULSE_CYC - 1))
            begin
               // RULE_16 back to read mode, selected
               next_st.rd_conv = 1'b1;
               next_st.state = H_WAIT;
            end
         end
         H_WAIT:
         begin
            // RULE_18 host bus idle during conversion
            if (!link.busy_n)
               next_st.busy_seen = 1'b1;
            else if (st.busy_seen && link.result_bus_oe)
            begin
               next_st.data = link.result_bus_o;
               next_st.valid = 1'b1;
               next_st.sel_n = 1'b1;
               next_st.state = H_IDLE;
            end
         end
         default:
            next_st.state = H_IDLE;
      endcase
   end
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         st.state <= H_IDLE;
         st.cnt <= '0;
         st.gap <= '0;
         st.sel_n <= 1'b1;
         st.rd_conv <= 1'b1;
         st.busy_seen <= 1'b0;
         st.data <= '0;
         st.valid <= 1'b0;
      end
      else
         st <= next_st;
   end
   assign link.sel_n = st.sel_n;
   assign link.rd_conv = st.rd_conv;
   assign rd_data = st.data;
   assign rd_valid = st.valid;
endmodule

// file: src/sac_link_if.sv
// Pin-level link between converter and host
`timescale 1ns/1ns
interface sac_link_if;
   logic sel_n;
   logic rd_conv;
   logic busy_n;
   logic [sac_pkg::RES_W-1:0] result_bus_o;
   logic result_bus_oe;
   modport dev
   (
      input sel_n,
      input rd_conv,
      output busy_n,
      output result_bus_o,
      output result_bus_oe
   );
   modport host
   (
      output sel_n,
      output rd_conv,
      input busy_n,
      input result_bus_o,
      input result_bus_oe
   );
endinterface

// file: src/sac_pkg.sv
// Shared constants of the converter control link
package sac_pkg;
   localparam int RES_W = 12;
   localparam int CLK_PERIOD_NS = 4;
   // Timing figures in ns, cycle counts derived from the clock period
   localparam int T_CONV_PULSE_NS = 40;
   localparam int T_BUSY_FALL_NS = 125;
   localparam int T_BUSY_LOW_NS = 1440;
   localparam int T_DATA_VALID_NS = 1460;
   localparam int T_BUSY_AFTER_DATA_NS = 20;
   localparam int T_SETUP_NS = 10;
   localparam int T_BETWEEN_CONV_NS = 1660;
   // Least times round up
   localparam int CONV_PULSE_CYC = (T_CONV_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BETWEEN_CONV_CYC = (T_BETWEEN_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BUSY_AFTER_DATA_CYC =
      (T_BUSY_AFTER_DATA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Longest times round down
   localparam int BUSY_LOW_CYC = T_BUSY_LOW_NS / CLK_PERIOD_NS;
   localparam int BUSY_FALL_CYC = T_BUSY_FALL_NS / CLK_PERIOD_NS;
   // Result is latched this many cycles after busy_n falls, at the longest busy time
   localparam int LATCH_CYC = BUSY_LOW_CYC - BUSY_AFTER_DATA_CYC;
   localparam int CNT_W = 12;
   // Reset value of the output register: midscale code
   localparam logic [RES_W-1:0] RESULT_RST = 12'h000;
   localparam logic [RES_W-1:0] CODE_POS_FS = 12'h7FF;
   localparam logic [RES_W-1:0] CODE_NEG_FS = 12'h800;
endpackage
